// >>> verilog/chadc_pkg.sv
// Package with constants and types for the charge converter back end
// Operation
// - Each result is a 20-bit count of the charge collected in one integration period.
// - Charge is accumulated for a whole integration period whose length the user selects.
// - The feedback DAC code is stepped at a 2 MHz rate from the comparator decision.
// - Each capacitor array element is switched to ground or reference by its code bit.
// - The filter sums the tracking output at the start and at the end of each period.
// - The result is the end data point minus the start data point.
// - The user programs the oversample count per data point.
// - Results enter a serial output register clocked apart from conversion timing.
// - The test current source is enabled while its pin is asserted.
package chadc_pkg;
	localparam int unsigned RES_W          = 20;
	localparam int unsigned DAC_W          = 20;
	localparam int unsigned ACC_W          = 32;
	localparam int unsigned OSR_W          = 8;
	localparam int unsigned TINT_W         = 24;
	localparam int unsigned SYS_CLK_HZ     = 200_000_000;
	localparam int unsigned TRACK_RATE_HZ  = 2_000_000;
	localparam int unsigned TRACK_DIV      = SYS_CLK_HZ / TRACK_RATE_HZ;
	localparam logic [DAC_W-1:0] DAC_RESET = 20'h8_0000;
	localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
	localparam logic [RES_W-1:0] RES_RESET = 20'h0_0000;

	typedef enum logic [1:0] {
		CHADC_IDLE,
		CHADC_START,
		CHADC_INTEG,
		CHADC_END
	} chadc_phase_t;
endpackage

// >>> verilog/chadc_skid.sv
// Two-entry buffer between the filter and the serial output register
`timescale 1ns/1ps
module chadc_skid #(
	parameter int unsigned WIDTH = 20
) (
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic [WIDTH-1:0] s_data_in,
	input  wire logic             s_valid_in,
	output logic                  s_ready_out,
	output logic      [WIDTH-1:0] m_data_out,
	output logic                  m_valid_out,
	input  wire logic             m_ready_in
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic [1:0]            cnt;
	} chadc_skid_t;

	chadc_skid_t st_reg;
	chadc_skid_t st_next;

	// Shift queue: slot 0 is the head
	always_comb begin
		logic push;
		logic pop;
		push = 1'b0;
		pop = 1'b0;
		st_next = st_reg;
		pop = m_valid_out && m_ready_in;
		push = s_valid_in && s_ready_out;
		if (pop) begin
			st_next.mem[0] = st_reg.mem[1];
			st_next.cnt = st_reg.cnt - 2'd1;
		end
		if (push) begin
			st_next.mem[st_next.cnt[0]] = s_data_in;
			st_next.cnt = st_next.cnt + 2'd1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign s_ready_out = (st_reg.cnt != 2'd2);
	assign m_valid_out = (st_reg.cnt != 2'd0);
	assign m_data_out  = st_reg.mem[0];
endmodule // chadc_skid

// >>> verilog/chadc_backend.sv
// Top of the charge converter digital back end: tracking, filter, serial output
`timescale 1ns/1ps
module chadc_backend
	import chadc_pkg::*;
(
	input  wire logic                       sys_clk_in,
	input  wire logic                       rstn_in,
	input  wire logic                       comp_in,
	input  wire logic [chadc_pkg::TINT_W-1:0] tint_ticks_in,
	input  wire logic [chadc_pkg::OSR_W-1:0] osr_count_in,
	input  wire logic                       test_src_pin_in,
	input  wire logic                       sclk_in,
	input  wire logic                       load_n_in,
	input  wire logic                       sdi_in,
	output logic [chadc_pkg::DAC_W-1:0]     capacitor_feedback_dac_out,
	output logic                            integ_reset_out,
	output logic                            test_src_en_out,
	output logic                            sdo_out,
	output logic                            result_ready_out,
	output logic                            overflow_out
);
	import chadc_pkg::*;

	typedef struct packed {
		logic [1:0]             rst_sync;
		logic [2:0]             comp_s;
		logic [2:0]             test_s;
		logic [2:0]             sclk_s;
		logic [2:0]             load_s;
		logic [2:0]             sdi_s;
		logic [7:0]             div;
		chadc_phase_t           phase;
		logic [TINT_W-1:0]      period;
		logic [OSR_W-1:0]       os_cnt;
		logic [OSR_W-1:0]       osr_lat;
		logic [DAC_W-1:0]       dac;
		logic [ACC_W-1:0]       acc;
		logic [ACC_W-1:0]       start_pt;
		logic [RES_W-1:0]       result;
		logic                   res_valid;
		logic [RES_W-1:0]       shreg;
		logic                   reading;
		logic                   sdo;
		logic                   ready_flag;
		logic                   ovf;
		logic                   integ_rst;
		logic                   comp_f;
		logic                   test_f;
	} chadc_top_t;

	chadc_top_t st_reg;
	chadc_top_t st_next;
	logic       rst_n;
	// Skid buffer handshake between the filter and the serial register
	logic [RES_W-1:0] buf_data;
	logic       buf_valid;
	logic       buf_in_ready;
	logic       buf_take;

	// Released reset copy for the skid buffer and the synchronous hold below; the raw pin still clears the register at once
	assign rst_n = st_reg.rst_sync[1];

	// Sum of the oversamples, kept at full accumulator width
	function automatic logic [ACC_W-1:0] chadc_add(input logic [ACC_W-1:0] a,
			input logic [DAC_W-1:0] b);
		chadc_add = a + {{(ACC_W-DAC_W){1'b0}}, b};
	endfunction

	// A change on a pin counts once the second and third stage agree
	function automatic logic chadc_pin(input logic [2:0] s, input logic old);
		chadc_pin = (s[1] == s[2]) ? s[2] : old;
	endfunction

	chadc_skid #(
		.WIDTH(RES_W)
	) u_skid (
		.clk_in      (sys_clk_in),
		.rstn_in     (rst_n),
		.s_data_in   (st_reg.result),
		.s_valid_in  (st_reg.res_valid),
		.s_ready_out (buf_in_ready),
		.m_data_out  (buf_data),
		.m_valid_out (buf_valid),
		.m_ready_in  (buf_take)
	);

	// Only load between transfers, while the host holds load inactive
	assign buf_take = !st_reg.reading && st_reg.load_s[2] && st_reg.load_s[1];

	// Next-state logic for the whole back end
	always_comb begin
		logic tick;
		logic sclk_rise;
		logic load_fall;
		logic load_rise;
		logic comp_q;
		logic [ACC_W-1:0] diff;
		tick = 1'b0;
		sclk_rise = 1'b0;
		load_fall = 1'b0;
		load_rise = 1'b0;
		comp_q = 1'b0;
		diff = '0;
		st_next = st_reg;
		// Pin synchronisers: three stages for comparator, test and host pins, two for the reset release
		st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};
		st_next.comp_s = {st_reg.comp_s[1:0], comp_in};
		st_next.test_s = {st_reg.test_s[1:0], test_src_pin_in};
		st_next.sclk_s = {st_reg.sclk_s[1:0], sclk_in};
		st_next.load_s = {st_reg.load_s[1:0], load_n_in};
		st_next.sdi_s = {st_reg.sdi_s[1:0], sdi_in};
		st_next.res_valid = st_reg.res_valid && !buf_in_ready;
		// Filtered levels: a change counts once the last two stages agree
		st_next.comp_f = chadc_pin(st_reg.comp_s, st_reg.comp_f);
		st_next.test_f = chadc_pin(st_reg.test_s, st_reg.test_f);
		comp_q = st_reg.comp_f;
		// Host edges are taken between the second and third stage, so each counts once
		sclk_rise = st_reg.sclk_s[1] && st_reg.sclk_s[2] == 1'b0;
		load_fall = !st_reg.load_s[1] && st_reg.load_s[2];
		load_rise = st_reg.load_s[1] && !st_reg.load_s[2];
		// Period start strobe lasts a single cycle
		st_next.integ_rst = 1'b0;
		// 2 MHz enable from the system clock divider
		if (st_reg.div == 8'(TRACK_DIV - 1)) begin
			st_next.div = '0;
			tick = 1'b1;
		end else begin
			st_next.div = st_reg.div + 8'd1;
		end
		if (tick) begin
			// Comparator high means node above ground: add feedback charge
			if (comp_q && st_reg.dac != '1) begin
				st_next.dac = st_reg.dac + 1'b1;
			end else if (!comp_q && st_reg.dac != '0) begin
				st_next.dac = st_reg.dac - 1'b1;
			end
			// Period sequencer: start samples, integration, end samples
			unique case (st_reg.phase)
				CHADC_IDLE: begin
					st_next.osr_lat = (osr_count_in == '0) ? 8'd1 : osr_count_in;
					st_next.os_cnt = '0;
					st_next.acc = ACC_RESET;
					st_next.period = '0;
					st_next.integ_rst = 1'b1;
					st_next.phase = CHADC_START;
				end
				CHADC_START: begin
					st_next.acc = chadc_add(st_reg.acc, st_reg.dac);
					st_next.os_cnt = st_reg.os_cnt + 8'd1;
					st_next.period = st_reg.period + 1'b1;
					// Start data point closes after the latched count of samples
					if (st_reg.os_cnt + 8'd1 == st_reg.osr_lat) begin
						st_next.start_pt = st_next.acc;
						st_next.acc = ACC_RESET;
						st_next.os_cnt = '0;
						st_next.phase = CHADC_INTEG;
					end
				end
				CHADC_INTEG: begin
					st_next.period = st_reg.period + 1'b1;
					if (st_reg.period + 24'(st_reg.osr_lat) >= tint_ticks_in) begin
						st_next.phase = CHADC_END;
					end
				end
				CHADC_END: begin
					st_next.acc = chadc_add(st_reg.acc, st_reg.dac);
					st_next.os_cnt = st_reg.os_cnt + 8'd1;
					if (st_reg.os_cnt + 8'd1 == st_reg.osr_lat) begin
						// Sums, not means: no division, full resolution kept
						diff = st_next.acc - st_reg.start_pt;
						st_next.result = diff[RES_W-1:0];
						st_next.ovf = diff[ACC_W-1:RES_W] != '0;
						st_next.res_valid = 1'b1;
						st_next.phase = CHADC_IDLE;
					end
				end
			endcase
		end
		// Serial register has its own timing, set by the host pins
		// A frame always starts, so the word already held is shifted even with the buffer empty
		if (load_fall) begin
			st_next.reading = 1'b1;
			st_next.ready_flag = 1'b0;
		end
		if (buf_take && buf_valid) begin
			st_next.shreg = buf_data;
			st_next.ready_flag = 1'b1;
		end
		// One bit leaves per host rising edge; the chain input enters at the bottom
		if (st_reg.reading && sclk_rise) begin
			st_next.sdo = st_reg.shreg[RES_W-1];
			st_next.shreg = {st_reg.shreg[RES_W-2:0], st_reg.sdi_s[2]};
		end
		if (load_rise) begin
			st_next.reading = 1'b0;
		end
	end

	// Reset clears the accumulators and holds the DAC mid-scale until released
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_reg <= '0;
			st_reg.dac <= DAC_RESET;
			st_reg.load_s <= 3'b111;
			st_reg.phase <= CHADC_IDLE;
		end else if (!rst_n) begin
			// Released copy still low: hold everything but the reset shifter
			st_reg <= '0;
			st_reg.rst_sync <= st_next.rst_sync;
			st_reg.dac <= DAC_RESET;
			st_reg.load_s <= 3'b111;
			st_reg.phase <= CHADC_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state register
	assign capacitor_feedback_dac_out = st_reg.dac;
	assign integ_reset_out = st_reg.integ_rst;
	assign test_src_en_out = st_reg.test_f;
	assign sdo_out = st_reg.sdo;
	assign result_ready_out = st_reg.ready_flag;
	assign overflow_out = st_reg.ovf;
endmodule // chadc_backend

// >>> sim/chadc_backend_asserts.sv
// Port checker for the charge converter back end
`timescale 1ns/1ps
module chadc_chk
	import chadc_pkg::*;
(
	input wire logic                        sys_clk_in,
	input wire logic                        rstn_in,
	input wire logic                        comp_in,
	input wire logic                        test_src_pin_in,
	input wire logic                        sclk_in,
	input wire logic                        load_n_in,
	input wire logic [chadc_pkg::DAC_W-1:0] capacitor_feedback_dac_out,
	input wire logic                        integ_reset_out,
	input wire logic                        test_src_en_out,
	input wire logic                        sdo_out,
	input wire logic                        result_ready_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	wire [DAC_W-1:0] dac = capacitor_feedback_dac_out;

	// Tracking moves one code per tick, upward while the comparator asks for feedback
	a_dac_step: assert property ($changed(dac) |->
		(dac - $past(dac)) inside {20'h0_0001, 20'hF_FFFF}) else $error("DAC jumped");
	a_dac_slow: assert property ($changed(dac) |=> $stable(dac) [*8])
		else $error("DAC stepped too fast");
	a_dac_up: assert property (comp_in [*8] ##0 $changed(dac) |-> dac > $past(dac))
		else $error("DAC moved against comparator");
	a_reset_mid: assert property ($rose(rstn_in) |-> dac == DAC_RESET)
		else $error("DAC not at reset code");
	// Test source follows its pin through the synchroniser
	a_test_on: assert property ($rose(test_src_pin_in) |-> ##[1:6] test_src_en_out)
		else $error("Test source not enabled");
	a_test_off: assert property ($fell(test_src_pin_in) |-> ##[1:6] !test_src_en_out)
		else $error("Test source not disabled");
	a_integ_pulse: assert property (integ_reset_out |=> !integ_reset_out)
		else $error("Period start pulse too long");
	// Serial register is not reloaded during a frame and its output changes only after a shift edge
	a_ready_holds: assert property (result_ready_out && load_n_in |=> result_ready_out)
		else $error("Unread result lost");
	a_no_reload: assert property (!load_n_in [*8] |-> !$rose(result_ready_out))
		else $error("Serial register reloaded during read");
	a_sdo_quiet: assert property ($rose(sclk_in) |-> $stable(sdo_out) [*2])
		else $error("Serial data changed too early");

	c_ready: cover property ($rose(result_ready_out));
	c_start: cover property (integ_reset_out);
	c_test: cover property ($rose(test_src_en_out));
endmodule // chadc_chk

bind chadc_backend chadc_chk chadc_chk_i (.*);

// >>> sim/chadc_host.sv
// Host model that reads the serial output register
`timescale 1ns/1ps
module chadc_host (
	input  wire logic sys_clk_in,
	input  wire logic sdo_in,
	output logic      sclk_out,
	output logic      load_n_out,
	output logic      sdi_out
);
	// Serial clock stands low and the frame is off between reads
	initial begin
		sclk_out = 1'b0;
		load_n_out = 1'b1;
		sdi_out = 1'b0;
	end

	// Levels held 6 cycles so the synchroniser sees each edge; bit taken late in high level
	task automatic read_word(output logic [19:0] w);
		w = 20'h0_0000;
		load_n_out <= 1'b0;
		repeat (6) @(negedge sys_clk_in);
		for (int i = 0; i < 20; i++) begin
			sclk_out <= 1'b1;
			sdi_out <= ~sdi_out; // Toggling chain input exposes a stuck shift
			repeat (6) @(negedge sys_clk_in);
			w = {w[18:0], sdo_in};
			sclk_out <= 1'b0;
			repeat (6) @(negedge sys_clk_in);
		end
		load_n_out <= 1'b1;
	endtask
endmodule // chadc_host

// >>> sim/chadc_backend_tb.sv
// Self-checking bench for the charge converter back end
`timescale 1ns/1ps
module chadc_backend_tb;
	import chadc_pkg::*;
	logic              clk, rstn, pin, sclk, load_n, sdi, ten, sdo, rdy, alt, ovf;
	logic              comp = 1'b1;
	logic [TINT_W-1:0] tint;
	logic [OSR_W-1:0]  osr;
	logic [DAC_W-1:0]  dac;
	logic [19:0]       w;
	int                n_fail = 0;
	int                n_tests = 0;
	int                cyc = 0;
	int                ph = 0;

	chadc_backend chadc_backend_i (.sys_clk_in(clk), .rstn_in(rstn), .comp_in(comp),
		.tint_ticks_in(tint), .osr_count_in(osr), .test_src_pin_in(pin), .sclk_in(sclk),
		.load_n_in(load_n), .sdi_in(sdi), .capacitor_feedback_dac_out(dac),
		.integ_reset_out(), .test_src_en_out(ten), .sdo_out(sdo),
		.result_ready_out(rdy), .overflow_out(ovf));
	chadc_host chadc_host_i (.sys_clk_in(clk), .sdo_in(sdo), .sclk_out(sclk),
		.load_n_out(load_n), .sdi_out(sdi));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Comparator toggles once per tick when dithering, so the DAC rocks between two codes
	always @(negedge clk) begin
		ph <= (ph == 99) ? 0 : ph + 1;
		if (ph == 99)
			comp <= alt ? ~comp : 1'b1;
	end

	// Hang guard, well above the expected run of about 14000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic test_source();
		pin = 1'b1;
		repeat (8) @(negedge clk);
		check(20'(ten), 20'h0_0001);
		pin = 1'b0;
		repeat (8) @(negedge clk);
		check(20'(ten), 20'h0_0000);
	endtask

	// Results drain through the skid buffer while no frame runs, so after the 4000-cycle wait all four reads were made wholly under the new settings
	task automatic convert(input logic mode, input logic [7:0] n);
		int k;
		alt = mode;
		osr = n;
		repeat (4000) @(negedge clk);
		repeat (4) begin
			k = 0;
			while (rdy !== 1'b1 && k < 8000) begin
				@(negedge clk);
				k++;
			end
			check(20'(rdy), 20'h0_0001);
			chadc_host_i.read_word(w);
		end
	endtask

	task automatic conv_dither();
		convert(1'b1, 8'h02);
		check(w, 20'h0_0000);
	endtask

	task automatic conv_ramp();
		convert(1'b0, 8'h04);
		check(w & 20'h0_0003, 20'h0_0000);
		check(20'(w == 20'h0_0000), 20'h0_0000);
		// Rising DAC: four end samples sit five codes above the four start samples
		check(w, 20'h0_0014);
		check(20'(ovf), 20'h0_0000);
	endtask

	// Reset in mid-run brings the DAC back to mid-scale and drops the ready flag
	task automatic reset_mid();
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		check(dac, DAC_RESET);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		check(dac, DAC_RESET);
		check(20'(rdy), 20'h0_0000);
	endtask

	initial begin
		rstn = 1'b0;
		alt = 1'b0;
		pin = 1'b0;
		tint = 24'h00_0008;
		osr = 8'h02;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		check(dac, DAC_RESET);
		check(20'(rdy), 20'h0_0000);
		test_source();
		conv_dither();
		conv_ramp();
		reset_mid();
		print_verdict();
	end
endmodule // chadc_backend_tb
